//--- rtl/vdt_pkg.sv
// Package with constants and carriers for the vehicle detect trigger output block.
// How it works
// - Trigger modes pulse the detection output low for one microsecond, then high.
// - Trigger mode pulses either at vehicle exit or at detection, one variant.
// - Trailing variant pulses at second-beam exit, just before message 4.
// - Leading variant pulses at first-beam detection, just before message 1.
// - Leading variant adds two edge bytes to messages 1, 2 and 3.
// - Presence mode holds output low while a vehicle is in beam two.
// - Presence falling edge pairs with message 2, rising edge with message 4.
// - One pulse per vehicle; presence stays active while a vehicle remains in beam two.
// - Each beam declares detection after 8 consecutive object scan lines.
// - Scan lines arrive at 360 per second per beam as the timebase.
// - Each beam declares exit about one foot after the last detecting scan.
// - Exit scan count follows the speed table from 120 down to 2.
// - Leading or trailing variant is fixed at production, not field settable.
// - Trigger or presence mode change takes effect only after reset.
// - Thresholds are the same whichever output mode is selected.
// - Output mode comes from nonvolatile configuration loaded at startup.
package vdt_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 125;
   localparam int unsigned PULSE_US       = 1;
   localparam int unsigned PULSE_CYC      = PULSE_US * CLK_MHZ;
   localparam int unsigned DET_SCANS      = 8;
   localparam int unsigned SCANS_PER_SEC  = 360;
   localparam int unsigned SCAN_CYC       = (CLK_MHZ * 1000000) / SCANS_PER_SEC;

   // ----------------------------------------------------------------------
   // Exit scan counts by speed class
   // ----------------------------------------------------------------------
   localparam logic [6:0] EXIT_MIN   = 7'h78;
   localparam logic [6:0] EXIT_20    = 7'h0C;
   localparam logic [6:0] EXIT_30    = 7'h08;
   localparam logic [6:0] EXIT_45    = 7'h05;
   localparam logic [6:0] EXIT_60    = 7'h04;
   localparam logic [6:0] EXIT_80    = 7'h03;
   localparam logic [6:0] EXIT_120   = 7'h02;

   typedef enum logic [2:0] {
      SPD_MIN = 3'b000,
      SPD_20  = 3'b001,
      SPD_30  = 3'b010,
      SPD_45  = 3'b011,
      SPD_60  = 3'b100,
      SPD_80  = 3'b101,
      SPD_120 = 3'b110
   } speed_e;

   typedef enum logic [1:0] {
      OUT_EXIT_TRIG  = 2'b00,
      OUT_DET_TRIG   = 2'b01,
      OUT_PRESENCE   = 2'b10
   } out_mode_e;

   localparam logic [2:0] MSG_DET1 = 3'h1;
   localparam logic [2:0] MSG_DET2 = 3'h2;
   localparam logic [2:0] MSG_EXIT1 = 3'h3;
   localparam logic [2:0] MSG_EXIT2 = 3'h4;

   // Per-beam scan sample.
   typedef struct packed {
      logic   scan;
      logic   object;
      speed_e speed;
   } beam_s;

   // Message request toward the framer.
   typedef struct packed {
      logic       valid;
      logic [2:0] number;
      logic       extra_bytes;
   } msg_s;

endpackage

//--- rtl/vehicle_detect_trigger_output.sv
// Beam qualification and detection output driver for the vehicle sensor.
`timescale 1ns/1ps
module vehicle_detect_trigger_output #(
   parameter int unsigned PULSE_CYCLES = vdt_pkg::PULSE_CYC
) (
   input  wire logic               sys_clk,
   input  wire logic               rst,
   input  wire logic               cfg_presence,
   input  wire logic               factory_leading,
   input  wire vdt_pkg::beam_s     beam1,
   input  wire vdt_pkg::beam_s     beam2,
   output logic                    detect_output_n,
   output vdt_pkg::msg_s           msg,
   output logic                    beam1_present,
   output logic                    beam2_present
);
   import vdt_pkg::*;

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic logic [6:0] exit_scans(input speed_e s);
      unique case (s)
         SPD_MIN: exit_scans = EXIT_MIN;
         SPD_20:  exit_scans = EXIT_20;
         SPD_30:  exit_scans = EXIT_30;
         SPD_45:  exit_scans = EXIT_45;
         SPD_60:  exit_scans = EXIT_60;
         SPD_80:  exit_scans = EXIT_80;
         default: exit_scans = EXIT_120;
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Mode latch
   // ----------------------------------------------------------------------
   // Configuration is caught on the first edge after reset release and held.
   logic      mode_loaded_r;
   logic      mode_loaded_nxt;
   out_mode_e mode_r;
   out_mode_e mode_nxt;

   always_comb begin
      mode_loaded_nxt = 1'b1;
      mode_nxt        = mode_r;
      if (!mode_loaded_r) begin
         if (cfg_presence)
            mode_nxt = OUT_PRESENCE;
         else if (factory_leading)
            mode_nxt = OUT_DET_TRIG;
         else
            mode_nxt = OUT_EXIT_TRIG;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_loaded_r <= 1'b0;
         mode_r        <= OUT_EXIT_TRIG;
      end else begin
         mode_loaded_r <= mode_loaded_nxt;
         mode_r        <= mode_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Beam qualification
   // ----------------------------------------------------------------------
   // Same thresholds in every output mode; the mode is never read here.
   logic [1:0] det_evt;
   logic [1:0] exit_evt;
   logic [1:0] present;
   beam_s      beams [2];
   assign beams[0] = beam1;
   assign beams[1] = beam2;

   for (genvar b = 0; b < 2; b++) begin : g_beam
      logic [3:0] hit_r;
      logic [3:0] hit_nxt;
      logic [6:0] miss_r;
      logic [6:0] miss_nxt;
      logic       pres_r;
      logic       pres_nxt;
      logic       det_c;
      logic       exit_c;

      always_comb begin
         hit_nxt  = hit_r;
         miss_nxt = miss_r;
         pres_nxt = pres_r;
         det_c    = 1'b0;
         exit_c   = 1'b0;
         if (beams[b].scan) begin
            if (beams[b].object) begin
               miss_nxt = '0;
               if (!pres_r) begin
                  hit_nxt = hit_r + 4'h1;
                  if (hit_nxt == 4'(DET_SCANS)) begin
                     det_c    = 1'b1;
                     pres_nxt = 1'b1;
                     hit_nxt  = '0;
                  end
               end
            end else begin
               hit_nxt = '0;
               if (pres_r) begin
                  miss_nxt = miss_r + 7'h01;
                  if (miss_nxt >= exit_scans(beams[b].speed)) begin
                     exit_c   = 1'b1;
                     pres_nxt = 1'b0;
                     miss_nxt = '0;
                  end
               end
            end
         end
      end

      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            hit_r  <= '0;
            miss_r <= '0;
            pres_r <= 1'b0;
         end else begin
            hit_r  <= hit_nxt;
            miss_r <= miss_nxt;
            pres_r <= pres_nxt;
         end
      end

      assign det_evt[b]  = det_c;
      assign exit_evt[b] = exit_c;
      assign present[b]  = pres_r;
   end

   assign beam1_present = present[0];
   assign beam2_present = present[1];

   // ----------------------------------------------------------------------
   // Output and message ordering
   // ----------------------------------------------------------------------
   logic [15:0] pulse_cnt_r;
   logic [15:0] pulse_cnt_nxt;
   logic        out_n_r;
   logic        out_n_nxt;
   msg_s        msg_r;
   msg_s        msg_nxt;
   logic        fire;
   logic        lead;

   assign lead = (mode_r == OUT_DET_TRIG);

   always_comb begin
      pulse_cnt_nxt = pulse_cnt_r;
      out_n_nxt     = out_n_r;
      msg_nxt       = '0;
      fire          = 1'b0;
      unique case (mode_r)
         OUT_EXIT_TRIG: fire = exit_evt[1];
         OUT_DET_TRIG:  fire = det_evt[0];
         default:       fire = 1'b0;
      endcase
      if (mode_r == OUT_PRESENCE) begin
         out_n_nxt = ~present[1];
         if (det_evt[1])
            out_n_nxt = 1'b0;
         if (exit_evt[1])
            out_n_nxt = 1'b1;
      end else if (pulse_cnt_r != '0) begin
         pulse_cnt_nxt = pulse_cnt_r - 16'h0001;
         if (pulse_cnt_r == 16'h0001)
            out_n_nxt = 1'b1;
      end else if (fire) begin
         pulse_cnt_nxt = 16'(PULSE_CYCLES);
         out_n_nxt     = 1'b0;
      end
      // The message request leaves on the same edge as the output change.
      // The framer sends it afterwards, so the pulse always comes first.
      if (det_evt[0]) begin
         msg_nxt = '{valid: 1'b1, number: MSG_DET1, extra_bytes: lead};
      end else if (det_evt[1]) begin
         msg_nxt = '{valid: 1'b1, number: MSG_DET2, extra_bytes: lead};
      end else if (exit_evt[0]) begin
         msg_nxt = '{valid: 1'b1, number: MSG_EXIT1, extra_bytes: lead};
      end else if (exit_evt[1]) begin
         msg_nxt = '{valid: 1'b1, number: MSG_EXIT2, extra_bytes: 1'b0};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pulse_cnt_r <= '0;
         out_n_r     <= 1'b1;
         msg_r       <= '0;
      end else begin
         pulse_cnt_r <= pulse_cnt_nxt;
         out_n_r     <= out_n_nxt;
         msg_r       <= msg_nxt;
      end
   end

   assign detect_output_n = out_n_r;
   assign msg             = msg_r;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_fire;
      (mode_r != OUT_PRESENCE) && fire && (pulse_cnt_r == '0);
   endsequence

   chk_pulse_falls: assert property (@(posedge sys_clk) disable iff (rst)
      s_fire |=> !detect_output_n ##(PULSE_CYCLES) detect_output_n)
      else $error("Trigger pulse width wrong.");
   chk_pulse_no_restart: assert property (@(posedge sys_clk) disable iff (rst)
      (pulse_cnt_r != '0) |=> (pulse_cnt_r == $past(pulse_cnt_r) - 16'h0001))
      else $error("Pulse counter restarted.");
   chk_lead_msg1: assert property (@(posedge sys_clk) disable iff (rst)
      (lead && det_evt[0] && pulse_cnt_r == '0) |=> !detect_output_n && msg.valid
         && msg.number == MSG_DET1)
      else $error("Leading pulse not paired with message 1.");
   chk_trail_msg4: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_r == OUT_EXIT_TRIG && exit_evt[1] && pulse_cnt_r == '0)
         |=> !detect_output_n && msg.number == MSG_EXIT2)
      else $error("Trailing pulse not paired with message 4.");
   chk_presence_lvl: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_r == OUT_PRESENCE && mode_loaded_r) |=> detect_output_n == !present[1])
      else $error("Presence level wrong.");
   chk_presence_edges: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_r == OUT_PRESENCE && exit_evt[1] && !det_evt[0] && !det_evt[1] && !exit_evt[0])
         |=> detect_output_n && msg.valid && msg.number == MSG_EXIT2)
      else $error("Presence release not paired with message 4.");
   chk_extra_bytes: assert property (@(posedge sys_clk) disable iff (rst)
      msg.valid && msg.number != MSG_EXIT2 |-> msg.extra_bytes == $past(lead))
      else $error("Extra byte flag wrong.");
   chk_mode_held: assert property (@(posedge sys_clk) disable iff (rst)
      mode_loaded_r |=> $stable(mode_r))
      else $error("Mode changed without reset.");
   chk_det_eight: assert property (@(posedge sys_clk) disable iff (rst)
      det_evt[0] |-> beam1.object && beam1.scan && g_beam[0].hit_r == 4'(DET_SCANS - 1))
      else $error("Detection before eight scans.");

endmodule

//--- bench/traffic_equipment.sv
// Model of the traffic equipment that samples the detection output line.
`timescale 1ns/1ps
module traffic_equipment (
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic detect_output_n,
   output int        pulses,
   output int        last_width
);
   int run;

   // Counts low periods and records the length of the last one in clocks.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run <= 0;
         pulses <= 0;
         last_width <= 0;
      end else if (detect_output_n === 1'b0) begin
         run <= run + 1;
      end else if (run != 0) begin
         pulses <= pulses + 1;
         last_width <= run;
         run <= 0;
      end
   end
endmodule

//--- bench/vehicle_detect_trigger_output_bench.sv
// Self-checking bench for the vehicle detect trigger output block.
`timescale 1ns/1ps
module vehicle_detect_trigger_output_bench;
   import vdt_pkg::*;
   localparam int unsigned PW = 4;
   logic   sys_clk, rst, cfg_presence, factory_leading;
   beam_s  beam1, beam2;
   logic   detect_output_n, beam1_present, beam2_present;
   msg_s   msg;
   int     n_mismatch, n_checks, pulses, last_width, seed;
   int     mcnt [8];
   logic   mext [8];
   speed_e spd;

   vehicle_detect_trigger_output #(.PULSE_CYCLES(PW)) u_vehicle_detect_trigger_output (
      .sys_clk(sys_clk), .rst(rst), .cfg_presence(cfg_presence),
      .factory_leading(factory_leading), .beam1(beam1), .beam2(beam2),
      .detect_output_n(detect_output_n), .msg(msg),
      .beam1_present(beam1_present), .beam2_present(beam2_present));

   traffic_equipment u_traffic_equipment (
      .sys_clk(sys_clk), .rst(rst), .detect_output_n(detect_output_n),
      .pulses(pulses), .last_width(last_width));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         foreach (mcnt[i]) mcnt[i] <= 0;
      end else if (msg.valid === 1'b1) begin
         mcnt[msg.number] <= mcnt[msg.number] + 1;
         mext[msg.number] <= msg.extra_bytes;
      end
   end

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic int exit_cnt(input speed_e s);
      case (s)
         SPD_MIN: return 120;
         SPD_20:  return 12;
         SPD_30:  return 8;
         SPD_45:  return 5;
         SPD_60:  return 4;
         SPD_80:  return 3;
         default: return 2;
      endcase
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic do_reset(input logic pres, input logic lead);
      @(negedge sys_clk);
      rst = 1'b1;
      cfg_presence = pres;
      factory_leading = lead;
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
   endtask

   // Sends n scan lines on one beam, one every two clocks.
   task automatic scan(input int b, input logic obj, input speed_e s, input int n);
      repeat (n) begin
         @(negedge sys_clk);
         if (b == 1) beam1 = '{1'b1, obj, s};
         else beam2 = '{1'b1, obj, s};
         @(negedge sys_clk);
         beam1.scan = 1'b0;
         beam2.scan = 1'b0;
      end
      repeat (2) @(negedge sys_clk);
   endtask

   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      seed = 32'h3131;
      rst = 1'b1;
      cfg_presence = 1'b0;
      factory_leading = 1'b1;
      beam1 = '0;
      beam2 = '0;
      n_mismatch = 0;
      n_checks = 0;
      do_reset(1'b0, 1'b1);
      chk(detect_output_n, 1'b1);
      scan(1, 1'b1, SPD_30, 7);
      scan(1, 1'b0, SPD_30, 1);
      scan(1, 1'b1, SPD_30, 7);
      chk(mcnt[1], 0);
      scan(1, 1'b1, SPD_30, 1);
      chk(detect_output_n, 1'b0);
      chk(mcnt[1], 1);
      chk(mext[1], 1'b1);
      chk(beam1_present, 1'b1);
      repeat (PW + 2) @(negedge sys_clk);
      chk(pulses, 1);
      chk(last_width, PW);
      scan(2, 1'b1, SPD_30, 8);
      chk(mext[2], 1'b1);
      chk(pulses, 1);
      chk(beam2_present, 1'b1);
      scan(1, 1'b0, SPD_45, 5);
      chk(beam1_present, 1'b0);
      chk(mcnt[3], 1);
      chk(mext[3], 1'b1);
      chk(pulses, 1);
      do_reset(1'b0, 1'b0);
      cfg_presence = 1'b1;
      for (int v = 0; v < 4; v++) begin
         spd = speed_e'(3'(($random(seed) & 32'h7FFF) % 7));
         if (v == 0) spd = SPD_MIN;
         if (v == 1) spd = SPD_120;
         scan(2, 1'b1, spd, 8);
         scan(2, 1'b0, spd, exit_cnt(spd) - 1);
         chk(mcnt[4], v);
         scan(2, 1'b0, spd, 1);
         chk(detect_output_n, 1'b0);
         chk(mcnt[4], v + 1);
         repeat (PW + 2) @(negedge sys_clk);
         chk(pulses, v + 1);
      end
      chk(mext[2], 1'b0);
      do_reset(1'b1, 1'b1);
      scan(2, 1'b1, SPD_45, 8);
      chk(detect_output_n, 1'b0);
      chk(mcnt[2], 1);
      chk(beam2_present, 1'b1);
      repeat (PW + 4) @(negedge sys_clk);
      chk(detect_output_n, 1'b0);
      scan(2, 1'b0, SPD_45, 5);
      chk(detect_output_n, 1'b1);
      chk(mcnt[4], 1);
      chk(beam2_present, 1'b0);
      give_verdict();
   end
endmodule
